// >>> src/resp_decoder_defs.vh
// constants for the card response decoder
`ifndef RESP_DECODER_DEFS_VH
`define RESP_DECODER_DEFS_VH
`define RT_R1        3'h0
`define RT_R1B       3'h1
`define RT_R2        3'h2
`define RT_R3        3'h3
`define RT_R4        3'h4
`define RT_R4B       3'h5
`define RT_R5        3'h6
`define RT_R6        3'h7
`define SHORT_LEN    8'h30
`define LONG_LEN     8'h88
`define IDX_ALL_ONES 6'h3F
`define IDX_ADDR_RSP 6'h28
`define RSV7_ONES    7'h7F
`define TIMEOUT_CK   8'h40
`endif

// >>> src/crc7_unit.v
// serial crc7 accumulator for the command line
`timescale 1ns/1ps
`default_nettype none
module crc7_unit (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clear,
  input  wire       shiftEn,
  input  wire       dataBit,
  output reg  [6:0] crc
);
  wire fb;
  assign fb = dataBit ^ crc[6];
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      crc <= 7'h00;
    else if (clear)
      crc <= 7'h00;
    else if (shiftEn)
      crc <= {crc[5:3], crc[2] ^ fb, crc[1:0], fb};
  end
endmodule
`default_nettype wire

// >>> src/card_response_decoder.v
// host-side framer and decoder of card responses on the command line
// How it works
// - bits arrive msb first and enter the shift register at the bottom, shifting left
// - frame must start with 0 then direction bit 0
// - crc7 checked on all types except the operating-conditions and i/o responses
// - last bit must be 1 as end marker
// - normal response is 48 bits, index in 45:40, 32-bit status
// - busy-capable response waits while data line is held low
// - long response is 136 bits, index all ones, register bits 127:1
// - erase busy holds data line low; host waits for release
// - conditions response has all-ones index and reserved bits 7:1
// - low level in conditions bit 31 means card still busy
// - fast i/o response splits address, register address and contents
// - i/o response gives ready, function count, memory flag, conditions
// - memory-only card flagged when memory present and zero functions
// - interrupt response carries relative address; zero means host-made
// - address response index 101000 with relative address and i/o status
`timescale 1ns/1ps
`default_nettype none
`include "resp_decoder_defs.vh"
module card_response_decoder (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         cardClk,
  input  wire         card_command_wire,
  input  wire         card_data_wire,
  input  wire         expectStart,
  input  wire [2:0]   expectType,
  input  wire [5:0]   expectIndex,
  output reg          respDone,
  output reg          respTimeout,
  output reg          crcError,
  output reg          frameError,
  output reg          indexError,
  output reg          busyWait,
  output reg  [5:0]   respIndex,
  output reg  [31:0]  respArg,
  output reg  [126:0] longData,
  output reg          cardBusy,
  output reg  [15:0]  cardRca,
  output reg  [7:0]   regAddr,
  output reg  [7:0]   regData,
  output reg  [2:0]   numFunctions,
  output reg          memPresent,
  output reg          memOnlyCard,
  output reg          hostMadeIrq,
  output reg  [2:0]   ioStatus
);
  localparam IDLE = 4'b0001;
  localparam WAIT = 4'b0010;
  localparam RECV = 4'b0100;
  localparam BUSY = 4'b1000;

  reg [2:0]   ckSync;
  reg [1:0]   cmdSync;
  reg [1:0]   datSync;
  reg [3:0]   state;
  reg [2:0]   typeReg;
  reg [5:0]   idxReg;
  reg [7:0]   bitCnt;
  reg [7:0]   waitCnt;
  reg [135:0] shiftReg;
  wire        ckRise;
  wire        cmdBit;
  wire        datBit;
  wire [6:0]  crcVal;
  wire        isLong;
  wire [7:0]  frameLen;
  wire        lastBit;
  wire        crcZone;
  wire [135:0] frame;

  // is this response type checked by crc
  function crcChecked;
    input [2:0] t;
    begin
      crcChecked = (t != `RT_R3) && (t != `RT_R4B);
    end
  endfunction

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ckSync  <= 3'h0;
      cmdSync <= 2'h3;
      datSync <= 2'h3;
    end
    else
    begin
      ckSync  <= {ckSync[1:0], cardClk};
      cmdSync <= {cmdSync[0], card_command_wire};
      datSync <= {datSync[0], card_data_wire};
    end
  end

  assign ckRise   = ckSync[1] & ~ckSync[2];
  assign cmdBit   = cmdSync[1];
  assign datBit   = datSync[1];
  assign isLong   = (typeReg == `RT_R2);
  assign frameLen = isLong ? `LONG_LEN : `SHORT_LEN;
  assign lastBit  = (bitCnt == frameLen - 8'h01);
  // crc covers all bits after the index for long responses, from bit 0 else
  assign crcZone  = isLong ? (bitCnt >= 8'h08) && (bitCnt < 8'h80)
                           : (bitCnt < 8'h28);
  assign frame    = {shiftReg[134:0], cmdBit};

  crc7_unit crcInst (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (state != RECV),
    .shiftEn (ckRise && (state == RECV) && crcZone),
    .dataBit (cmdBit),
    .crc     (crcVal)
  );

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state        <= IDLE;
      typeReg      <= 3'h0;
      idxReg       <= 6'h00;
      bitCnt       <= 8'h00;
      waitCnt      <= 8'h00;
      shiftReg     <= 136'h0;
      respDone     <= 1'b0;
      respTimeout  <= 1'b0;
      crcError     <= 1'b0;
      frameError   <= 1'b0;
      indexError   <= 1'b0;
      busyWait     <= 1'b0;
      respIndex    <= 6'h00;
      respArg      <= 32'h0;
      longData     <= 127'h0;
      cardBusy     <= 1'b0;
      cardRca      <= 16'h0;
      regAddr      <= 8'h00;
      regData      <= 8'h00;
      numFunctions <= 3'h0;
      memPresent   <= 1'b0;
      memOnlyCard  <= 1'b0;
      hostMadeIrq  <= 1'b0;
      ioStatus     <= 3'h0;
    end
    else
    begin
      respDone    <= 1'b0;
      respTimeout <= 1'b0;
      case (state)
        IDLE:
        begin
          if (expectStart)
          begin
            typeReg <= expectType;
            idxReg  <= expectIndex;
            waitCnt <= 8'h00;
            state   <= WAIT;
          end
        end
        WAIT:
        begin
          if (ckRise)
          begin
            if (!cmdBit)
            begin
              shiftReg <= {135'h0, cmdBit};
              bitCnt   <= 8'h01;
              state    <= RECV;
            end
            else if (waitCnt == `TIMEOUT_CK)
            begin
              respTimeout <= 1'b1;
              state       <= IDLE;
            end
            else
              waitCnt <= waitCnt + 8'h01;
          end
        end
        RECV:
        begin
          if (ckRise)
          begin
            shiftReg <= frame;
            bitCnt   <= bitCnt + 8'h01;
            if (lastBit)
            begin
              respDone <= ~(typeReg == `RT_R1B);
              frameError <= frame[frameLen - 8'h02] | ~cmdBit |
                            ((typeReg == `RT_R3) && (frame[7:1] != `RSV7_ONES));
              crcError <= crcChecked(typeReg) &&
                          (frame[7:1] != crcVal);
              if (isLong)
              begin
                respIndex  <= frame[133:128];
                longData   <= frame[127:1];
                indexError <= frame[133:128] != `IDX_ALL_ONES;
              end
              else
              begin
                respIndex <= frame[45:40];
                respArg   <= frame[39:8];
                case (typeReg)
                  `RT_R3, `RT_R4, `RT_R5:
                    indexError <= frame[45:40] != `IDX_ALL_ONES;
                  `RT_R6:
                    indexError <= frame[45:40] != `IDX_ADDR_RSP;
                  `RT_R4B:
                    indexError <= 1'b0;
                  default:
                    indexError <= frame[45:40] != idxReg;
                endcase
                cardBusy <= ~frame[39];
                if (typeReg == `RT_R4 || typeReg == `RT_R5 || typeReg == `RT_R6)
                  cardRca <= frame[39:24];
                if (typeReg == `RT_R4)
                begin
                  regAddr <= frame[23:16];
                  regData <= frame[15:8];
                end
                // flag describes the latest short response only
                hostMadeIrq <= (typeReg == `RT_R5) && (frame[39:24] == 16'h0000);
                if (typeReg == `RT_R6)
                  ioStatus <= frame[23:21];
                if (typeReg == `RT_R4B)
                begin
                  numFunctions <= frame[38:36];
                  memPresent   <= frame[35];
                  memOnlyCard  <= frame[35] && frame[38:36] == 3'h0;
                end
              end
              if (typeReg == `RT_R1B)
              begin
                busyWait <= 1'b1;
                state    <= BUSY;
              end
              else
                state <= IDLE;
            end
          end
        end
        BUSY:
        begin
          if (ckRise && datBit)
          begin
            busyWait <= 1'b0;
            respDone <= 1'b1;
            state    <= IDLE;
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verif/card_response_decoder_properties.sv
// port checks for the card response decoder
`timescale 1ns/1ps
`default_nettype none
`include "resp_decoder_defs.vh"
module resp_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        card_data_wire,
  input wire logic        expectStart,
  input wire logic [2:0]  expectType,
  input wire logic        respDone,
  input wire logic        busyWait,
  input wire logic [31:0] respArg,
  input wire logic [15:0] cardRca,
  input wire logic [7:0]  regData,
  input wire logic [2:0]  numFunctions,
  input wire logic        memPresent,
  input wire logic        memOnlyCard,
  input wire logic        hostMadeIrq,
  input wire logic [2:0]  ioStatus
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_frame_min: assert property (expectStart |=> !respDone [*8])
    else $error("done too soon after arming");
  a_busy_blocks: assert property (busyWait |-> !respDone)
    else $error("done while busy");
  a_busy_stays: assert property (busyWait && !card_data_wire |=> busyWait)
    else $error("busy dropped with data low");
  a_fast_fields: assert property (respDone && expectType == `RT_R4 |->
    cardRca == respArg[31:16] && regData == respArg[7:0])
    else $error("fast io fields wrong");
  a_io_fields: assert property (respDone && expectType == `RT_R4B |->
    numFunctions == respArg[30:28] && memPresent == respArg[27])
    else $error("io fields wrong");
  a_memonly_needs: assert property (memOnlyCard |-> memPresent && numFunctions == 3'h0)
    else $error("memory-only flag wrong");
  a_host_zero: assert property (hostMadeIrq |-> cardRca == 16'h0000)
    else $error("host irq with address");
  a_io_status: assert property (respDone && expectType == `RT_R6 |->
    ioStatus == respArg[15:13])
    else $error("io status wrong");
endmodule
bind card_response_decoder resp_checker u_chk (.clk, .reset_n, .card_data_wire, .expectStart,
  .expectType, .respDone, .busyWait, .respArg, .cardRca, .regData, .numFunctions, .memPresent,
  .memOnlyCard, .hostMadeIrq, .ioStatus);
`default_nettype wire

// >>> verif/card_model.sv
// card side: clocks a response out and holds data busy
`timescale 1ns/1ps
`default_nettype none
module card_model (
  output logic cardClk,
  output logic cmdLine,
  output logic datLine
);
  // lines pulled up, clock still between frames
  initial
  begin
    cardClk = 1'b0;
    cmdLine = 1'b1;
    datLine = 1'b1;
  end
  task send(input logic [135:0] f, input int n, input int busy);
    for (int i = n - 1; i >= 0; i--)
    begin
      cmdLine = f[i];
      #62.5 cardClk = 1'b1;
      #62.5 cardClk = 1'b0;
    end
    cmdLine = 1'b1;
    datLine = (busy == 0);
    // keep clocking through busy so its release is seen, then two trailing clocks
    for (int i = 0; i <= busy + 1; i++)
    begin
      if (i == busy)
        datLine = 1'b1;
      #62.5 cardClk = 1'b1;
      #62.5 cardClk = 1'b0;
    end
  endtask
  // clocks with the command line left high: a card that never answers
  task idle(input int n);
    cmdLine = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      #62.5 cardClk = 1'b1;
      #62.5 cardClk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_card_response_decoder.sv
// self-checking bench for the card response decoder
`timescale 1ns/1ps
`default_nettype none
`include "resp_decoder_defs.vh"
module tb_card_response_decoder;
  logic         clk, reset_n, expectStart;
  logic [2:0]   expectType;
  logic [5:0]   expectIndex;
  wire          cardClk, card_command_wire, card_data_wire, respDone, crcError, frameError;
  wire          indexError, busyWait, cardBusy, memOnlyCard, hostMadeIrq, respTimeout;
  wire  [2:0]   ioStatus;
  wire  [5:0]   respIndex;
  wire  [7:0]   regAddr, regData;
  wire  [15:0]  cardRca;
  wire  [31:0]  respArg;
  wire  [126:0] longData;
  int           miscompares, checked;
  card_model u_card (.cardClk, .cmdLine(card_command_wire), .datLine(card_data_wire));
  card_response_decoder u_dut (.clk, .reset_n, .cardClk, .card_command_wire, .card_data_wire,
    .expectStart, .expectType, .expectIndex, .respDone, .respTimeout, .crcError, .frameError,
    .indexError, .busyWait, .respIndex, .respArg, .longData, .cardBusy, .cardRca, .regAddr,
    .regData, .numFunctions(), .memPresent(), .memOnlyCard, .hostMadeIrq, .ioStatus);
  function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[5:0], d[i] ^ c[6]} ^ ({7{d[i] ^ c[6]}} & 7'h08);
    return c;
  endfunction
  function automatic logic [47:0] mk(input logic [5:0] idx, input logic [31:0] a);
    return {2'h0, idx, a, crc7({82'h0, idx, a}, 40), 1'b1};
  endfunction
  task chk(input logic [126:0] s, input logic [126:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task shot(input logic [2:0] t, input logic [5:0] ei, input logic [135:0] f, input int n,
    input int busy);
    int k;
    @(posedge clk);
    expectType <= t;
    expectIndex <= ei;
    expectStart <= 1'b1;
    @(posedge clk);
    expectStart <= 1'b0;
    fork
      u_card.send(f, n, busy);
    join_none
    for (k = 0; k < 5000 && respDone !== 1'b1; k++)
      @(negedge clk);
    if (k == 5000)
    begin
      miscompares++;
      close_out();
    end
    wait fork;
  endtask
  task test_normal;
    shot(`RT_R1, 6'h37, mk(6'h37, 32'h12345678), 48, 0);
    chk(respIndex, 6'h37);
    chk(respArg, 32'h12345678);
    chk({crcError, frameError, indexError}, 3'h0);
    shot(`RT_R1, 6'h38, mk(6'h38, 32'h00000900), 48, 0);
    chk({respIndex, indexError}, 7'h70);
    $display("normal frame done");
  endtask
  task test_errors;
    shot(`RT_R1, 6'h11, mk(6'h11, 32'h0) ^ 48'h2, 48, 0);
    chk(crcError, 1'b1);
    shot(`RT_R1, 6'h11, mk(6'h11, 32'h0) ^ 48'h1, 48, 0);
    chk(frameError, 1'b1);
    shot(`RT_R1, 6'h11, mk(6'h11, 32'h0) | 48'h400000000000, 48, 0);
    chk(frameError, 1'b1);
    shot(`RT_R1, 6'h12, mk(6'h11, 32'h0), 48, 0);
    chk(indexError, 1'b1);
    $display("error frames done");
  endtask
  task test_kinds;
    shot(`RT_R3, 6'h3F, {8'h3F, 32'h7FFF8000, 8'hFF}, 48, 0);
    chk({crcError, cardBusy, respArg}, {2'h1, 32'h7FFF8000});
    shot(`RT_R4, 6'h3F, mk(6'h3F, 32'hBEEF12A5), 48, 0);
    chk({cardRca, regAddr, regData}, 32'hBEEF12A5);
    shot(`RT_R4B, 6'h3F, mk(6'h3F, 32'h88FF8000), 48, 0);
    chk(memOnlyCard, 1'b1);
    shot(`RT_R5, 6'h3F, mk(6'h3F, 32'h0000CAFE), 48, 0);
    chk({hostMadeIrq, cardRca}, 17'h10000);
    shot(`RT_R6, 6'h28, mk(6'h28, 32'h4321A000), 48, 0);
    chk({cardRca, ioStatus}, 19'h2190D);
    $display("response kinds done");
  endtask
  task test_busy;
    fork
      shot(`RT_R1B, 6'h1C, mk(6'h1C, 32'h0), 48, 40);
      begin
        #8000;
        chk({busyWait, respDone}, 2'h2);
      end
    join
    chk(busyWait, 1'b0);
    $display("busy frame done");
  endtask
  task test_silent;
    int k;
    @(posedge clk);
    expectType <= `RT_R1;
    expectIndex <= 6'h01;
    expectStart <= 1'b1;
    @(posedge clk);
    expectStart <= 1'b0;
    fork
      u_card.idle(70);
    join_none
    for (k = 0; k < 3000 && respTimeout !== 1'b1; k++)
      @(negedge clk);
    if (k == 3000)
    begin
      miscompares++;
      close_out();
    end
    chk({respTimeout, respDone}, 2'h2);
    wait fork;
    $display("silent card done");
  endtask
  task test_long;
    shot(`RT_R2, 6'h3F, {8'h3F, 120'h00112233445566778899AABBCCDDEE,
      crc7(120'h00112233445566778899AABBCCDDEE, 120), 1'b1}, 136, 0);
    chk(longData, {120'h00112233445566778899AABBCCDDEE,
      crc7(120'h00112233445566778899AABBCCDDEE, 120)});
    chk(crcError, 1'b0);
    $display("long frame done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    reset_n = 1'b0;
    expectStart = 1'b0;
    expectType = 3'h0;
    expectIndex = 6'h00;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    test_normal();
    test_errors();
    test_kinds();
    test_busy();
    test_long();
    test_silent();
    close_out();
  end
endmodule
`default_nettype wire
